// ===== rtl/isr_map.svh
// Constants of the indication signal router: source codes, timing, widths.
// Assumes inclusion by bare name from the package and the router module.
`ifndef ISR_MAP_SVH
`define ISR_MAP_SVH

// Source select codes
`define ISR_SRC_ONE         5'h00
`define ISR_SRC_ZERO        5'h01
`define ISR_SRC_START_LOCK  5'h02
`define ISR_SRC_TEACH_PC    5'h03
`define ISR_SRC_TEACH_OVR   5'h04
`define ISR_SRC_FAULT       5'h05
`define ISR_SRC_DIRTY       5'h06
`define ISR_SRC_WEAK        5'h07
`define ISR_SRC_LED_YELLOW  5'h08
`define ISR_SRC_MUTING      5'h09
`define ISR_SRC_SSO_FAULT   5'h0A
`define ISR_SRC_SSO_STATE   5'h0B
`define ISR_SRC_MAGNET      5'h0C
`define ISR_SRC_OPT_BRIDGE  5'h0D
`define ISR_SRC_FIELD_FREE  5'h0E
`define ISR_SRC_KEY_FITTED  5'h0F
`define ISR_SRC_LINE_BASE   5'h10
`define ISR_SRC_W           5
`define ISR_NUM_SRC         32

// Function setting codes
`define ISR_FN_OFF          2'h0
`define ISR_FN_DIRECT       2'h1
`define ISR_FN_INVERT       2'h2

// Dirty window persistence time
`define ISR_DIRTY_MIN       10
`define ISR_CLK_HZ          100000000
`define ISR_DIRTY_CYC       (64'(`ISR_DIRTY_MIN) * 64'd60 * 64'(`ISR_CLK_HZ))

// Reset values
`define ISR_OUT_RST         1'b0

`endif

// ===== rtl/isr_pkg.sv
// Types of the indication signal router.
// Assumes isr_map.svh is on the include path.
`default_nettype none
`include "isr_map.svh"
package isr_pkg;

  typedef enum logic [1:0] {
    ISR_FN_OFF_E    = `ISR_FN_OFF,
    ISR_FN_DIRECT_E = `ISR_FN_DIRECT,
    ISR_FN_INVERT_E = `ISR_FN_INVERT
  } isr_fn_e;

  // One channel's configuration
  typedef struct packed {
    isr_fn_e                fn;
    logic [`ISR_SRC_W-1:0]  src;
    logic [1:0]             line;
  } isr_chan_cfg_s;

  // Internal status flags from the receiver
  typedef struct packed {
    logic start_lock_en;
    logic start_unlocked;
    logic teach_pc;
    logic teach_ovr;
    logic error;
    logic fault;
    logic weak_beam;
    logic weak_edge_only;
    logic led_yellow;
    logic muting;
    logic sso_state;
    logic sso_fault;
    logic magnet;
    logic opt_bridge;
    logic field_free;
  } isr_status_s;

  // Channel output state machine, one-hot
  typedef enum logic [2:0] {
    ISR_CH_IDLE   = 3'b001,
    ISR_CH_DIRECT = 3'b010,
    ISR_CH_INVERT = 3'b100
  } isr_ch_state_e;

endpackage : isr_pkg
`default_nettype wire

// ===== rtl/isr_indication_router.sv
// Indication signal router: two channels route a chosen internal signal onto
// a chosen indication line, direct or inverted. Assumes synchronous inputs.
`default_nettype none
`include "isr_map.svh"
module isr_indication_router
  import isr_pkg::*;
#(
  parameter int          NUM_LINES  = 16,
  parameter int          NUM_OUT    = 4,
  parameter longint      DIRTY_CYC  = `ISR_DIRTY_CYC
) (
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_sys_rst,
  input  wire logic                 i_clk_en,
  input  wire isr_status_s          i_status,
  input  wire logic [NUM_LINES-1:0] i_logic_lines,
  input  wire isr_chan_cfg_s        i_cfg_a,
  input  wire isr_chan_cfg_s        i_cfg_b,
  output var  logic [NUM_OUT-1:0]   o_ind_line,
  output var  logic [NUM_OUT-1:0]   o_ind_line_used,
  output var  logic                 o_start_locked,
  output var  logic                 o_dirty_window,
  output var  logic                 o_cfg_conflict
);

  localparam int CNT_W = $clog2(DIRTY_CYC + 1);
  localparam int NSRC  = `ISR_NUM_SRC;
  localparam int LBASE = int'(`ISR_SRC_LINE_BASE);

  initial begin
    if (NUM_LINES < 1 || LBASE + NUM_LINES > NSRC) begin
      $error("NUM_LINES does not fit the source select range");
    end
    if (NUM_OUT < 2 || NUM_OUT > 4) begin
      $error("NUM_OUT must lie between 2 and 4");
    end
    if (DIRTY_CYC < 1) begin
      $error("DIRTY_CYC must be at least one");
    end
  end

  // Start interlock: set at reset, held until unlocked
  logic start_lock_reg;
  logic start_lock_next;
  assign start_lock_next = start_lock_reg & ~i_status.start_unlocked;

  // Weak beam persistence counter
  logic             weak_beam;
  logic [CNT_W-1:0] weak_cnt_reg;
  logic [CNT_W-1:0] weak_cnt_next;
  logic             weak_full;
  logic             dirty_reg;
  logic             dirty_next;

  assign weak_beam     = i_status.weak_beam & ~i_status.weak_edge_only;
  assign weak_full     = (weak_cnt_reg == CNT_W'(DIRTY_CYC));
  assign weak_cnt_next = !weak_beam ? '0 :
                         weak_full  ? weak_cnt_reg :
                                      weak_cnt_reg + CNT_W'(1);
  assign dirty_next    = weak_beam & (weak_full | (weak_cnt_reg == CNT_W'(DIRTY_CYC - 1)));

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      start_lock_reg <= 1'b1;
      weak_cnt_reg   <= '0;
      dirty_reg      <= 1'b0;
    end else if (i_clk_en) begin
      start_lock_reg <= start_lock_next;
      weak_cnt_reg   <= weak_cnt_next;
      dirty_reg      <= dirty_next;
    end
  end

  // Source vector indexed by select code
  logic [NSRC-1:0] src_vec;

  assign src_vec[`ISR_SRC_ONE]        = 1'b1;
  assign src_vec[`ISR_SRC_ZERO]       = 1'b0;
  assign src_vec[`ISR_SRC_START_LOCK] = start_lock_reg & i_status.start_lock_en;
  assign src_vec[`ISR_SRC_TEACH_PC]   = i_status.teach_pc;
  assign src_vec[`ISR_SRC_TEACH_OVR]  = i_status.teach_ovr;
  assign src_vec[`ISR_SRC_FAULT]      = i_status.error | i_status.fault;
  // Same edge as o_dirty_window, so the routed line and the flag agree
  assign src_vec[`ISR_SRC_DIRTY]      = dirty_next;
  assign src_vec[`ISR_SRC_WEAK]       = weak_beam;
  assign src_vec[`ISR_SRC_LED_YELLOW] = i_status.led_yellow;
  assign src_vec[`ISR_SRC_MUTING]     = i_status.muting;
  assign src_vec[`ISR_SRC_SSO_FAULT]  = i_status.sso_fault;
  assign src_vec[`ISR_SRC_SSO_STATE]  = i_status.sso_state;
  assign src_vec[`ISR_SRC_MAGNET]     = i_status.magnet;
  assign src_vec[`ISR_SRC_OPT_BRIDGE] = i_status.opt_bridge;
  assign src_vec[`ISR_SRC_KEY_FITTED] = i_status.magnet & i_status.opt_bridge;
  assign src_vec[`ISR_SRC_FIELD_FREE] = i_status.field_free;

  // Logical lines, unfiltered; unused codes read zero
  genvar g;
  generate
    for (g = LBASE; g < NSRC; g++) begin : g_line_src
      if (g - LBASE < NUM_LINES) begin : g_used
        assign src_vec[g] = i_logic_lines[g - LBASE];
      end else begin : g_unused
        assign src_vec[g] = 1'b0;
      end
    end
  endgenerate

  // Per-channel selection and polarity
  isr_chan_cfg_s cfg [2];
  assign cfg[0] = i_cfg_a;
  assign cfg[1] = i_cfg_b;

  isr_ch_state_e    ch_state_reg  [2];
  isr_ch_state_e    ch_state_next [2];
  logic [1:0]       ch_level;
  logic [1:0]       ch_active;
  logic [1:0]       ch_line_ok;

  generate
    for (g = 0; g < 2; g++) begin : g_chan
      logic sel_bit;
      assign sel_bit       = src_vec[cfg[g].src];
      assign ch_line_ok[g] = (int'(cfg[g].line) < NUM_OUT);
      assign ch_state_next[g] =
        (cfg[g].fn == ISR_FN_DIRECT_E && ch_line_ok[g]) ? ISR_CH_DIRECT :
        (cfg[g].fn == ISR_FN_INVERT_E && ch_line_ok[g]) ? ISR_CH_INVERT :
                                                          ISR_CH_IDLE;

      always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
          ch_state_reg[g] <= ISR_CH_IDLE;
        end else if (i_clk_en) begin
          ch_state_reg[g] <= ch_state_next[g];
        end
      end

      always_comb begin
        case (ch_state_next[g])
          ISR_CH_DIRECT: begin
            ch_level[g]  = sel_bit;
            ch_active[g] = 1'b1;
          end
          ISR_CH_INVERT: begin
            ch_level[g]  = ~sel_bit;
            ch_active[g] = 1'b1;
          end
          default: begin
            ch_level[g]  = `ISR_OUT_RST;
            ch_active[g] = 1'b0;
          end
        endcase
      end
    end
  endgenerate

  // Output line drive; channel A wins a shared line
  logic [NUM_OUT-1:0] line_next;
  logic [NUM_OUT-1:0] used_next;
  logic               conflict_next;

  generate
    for (g = 0; g < NUM_OUT; g++) begin : g_out
      logic hit_a;
      logic hit_b;
      assign hit_a = ch_active[0] && (int'(cfg[0].line) == g);
      assign hit_b = ch_active[1] && (int'(cfg[1].line) == g);
      assign line_next[g] = hit_a ? ch_level[0] :
                            hit_b ? ch_level[1] : `ISR_OUT_RST;
      assign used_next[g] = hit_a | hit_b;
    end
  endgenerate

  assign conflict_next = ch_active[0] & ch_active[1] & (cfg[0].line == cfg[1].line);

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_ind_line      <= '0;
      o_ind_line_used <= '0;
      o_start_locked  <= 1'b1;
      o_dirty_window  <= 1'b0;
      o_cfg_conflict  <= 1'b0;
    end else if (i_clk_en) begin
      o_ind_line      <= line_next;
      o_ind_line_used <= used_next;
      o_start_locked  <= start_lock_next;
      o_dirty_window  <= dirty_next;
      o_cfg_conflict  <= conflict_next;
    end
  end

endmodule : isr_indication_router
`default_nettype wire

// ===== tb/isr_router_props.sv
// Port checker of the indication router.
// Assumes it is bound onto the router top.
`default_nettype none
`include "isr_map.svh"
module isr_router_props
  import isr_pkg::*;
#(
  parameter int     NUM_OUT   = 4,
  parameter longint DIRTY_CYC = 20
) (
  input wire logic               i_clk_sys,
  input wire logic               i_sys_rst,
  input wire logic               i_clk_en,
  input wire isr_status_s        i_status,
  input wire isr_chan_cfg_s      i_cfg_a,
  input wire isr_chan_cfg_s      i_cfg_b,
  input wire logic [NUM_OUT-1:0] o_ind_line,
  input wire logic [NUM_OUT-1:0] o_ind_line_used,
  input wire logic               o_start_locked,
  input wire logic               o_dirty_window
);
  timeunit 1ns;
  timeprecision 1ps;
  logic   run_en;
  logic   a_dir;
  logic   a_inv;
  logic   b_dir;
  longint run_reg;
  assign run_en = i_clk_en && !i_sys_rst;
  assign a_dir  = run_en && i_cfg_a.fn == ISR_FN_DIRECT_E;
  assign a_inv  = run_en && i_cfg_a.fn == ISR_FN_INVERT_E;
  assign b_dir  = run_en && i_cfg_b.fn == ISR_FN_DIRECT_E;
  // Consecutive enabled weak cycles
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst || (i_clk_en && !(i_status.weak_beam && !i_status.weak_edge_only)))
      run_reg <= 0;
    else if (i_clk_en && run_reg < DIRTY_CYC)
      run_reg <= run_reg + 1;
  end
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  a_direct_one: assert property ($past(a_dir && i_cfg_a.src == `ISR_SRC_ONE)
    |-> o_ind_line[$past(i_cfg_a.line)]) else $error("Direct one lost");
  a_invert_mute: assert property ($past(a_inv && i_cfg_a.src == `ISR_SRC_MUTING)
    |-> o_ind_line[$past(i_cfg_a.line)] != $past(i_status.muting)) else $error("Bad invert");
  a_b_own_line: assert property ($past(b_dir && i_cfg_b.line != i_cfg_a.line &&
    i_cfg_b.src == `ISR_SRC_FIELD_FREE) |-> o_ind_line[$past(i_cfg_b.line)] ==
    $past(i_status.field_free)) else $error("Channel B wrong");
  a_used_mark: assert property ($past(a_dir || a_inv)
    |-> o_ind_line_used[$past(i_cfg_a.line)]) else $error("Used flag lost");
  a_off_unused: assert property ($past(run_en && !a_dir && !a_inv && !b_dir &&
    i_cfg_b.fn != ISR_FN_INVERT_E) |-> o_ind_line_used == '0 && o_ind_line == '0)
    else $error("Off channel drives");
  a_freeze_hold: assert property ($past(!i_clk_en && !i_sys_rst) |-> $stable(o_ind_line))
    else $error("Moved while disabled");
  a_lock_release: assert property (o_start_locked && i_clk_en && i_status.start_unlocked
    |=> !o_start_locked) else $error("Lock kept");
  a_dirty_span: assert property (o_dirty_window == (run_reg >= DIRTY_CYC))
    else $error("Dirty timing wrong");
endmodule : isr_router_props

bind isr_indication_router isr_router_props #(.NUM_OUT(NUM_OUT), .DIRTY_CYC(DIRTY_CYC)) u_props (
  .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en), .i_status(i_status),
  .i_cfg_a(i_cfg_a), .i_cfg_b(i_cfg_b), .o_ind_line(o_ind_line),
  .o_ind_line_used(o_ind_line_used), .o_start_locked(o_start_locked),
  .o_dirty_window(o_dirty_window));
`default_nettype wire

// ===== tb/isr_plc_model.sv
// Controller model: two indication lines read as an antivalent pair.
// Assumes the lines come straight from the router.
`default_nettype none
module isr_plc_model (
  input  wire logic i_line_p,
  input  wire logic i_line_n,
  input  wire logic i_sso_on,
  output var  logic o_pair_ok,
  output var  logic o_release
);
  timeunit 1ns;
  timeprecision 1ps;
  assign o_pair_ok = i_line_p != i_line_n;
  assign o_release = o_pair_ok && i_line_p && i_sso_on;
endmodule : isr_plc_model
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench of the indication router.
// Assumes router, package, checker and controller model compiled first.
`default_nettype none
`include "isr_map.svh"
module testbench
  import isr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DC = 20;
  logic          clk = 1'b0;
  logic          rst = 1'b1;
  logic          en = 1'b1;
  isr_status_s   st = '0;
  logic [15:0]   ln = '0;
  isr_chan_cfg_s ca = '0;
  isr_chan_cfg_s cb = '0;
  logic [3:0]    ind, used, e_ind, e_used;
  logic          locked, dirty, conf, e_conf, pair_ok, rel_ok;
  logic          e_lock = 1'b1;
  int            run, err_total, total_checks;
  integer        seed = 32'h29B5;
  always #5 clk = ~clk;
  isr_indication_router #(.DIRTY_CYC(DC)) dut (.i_clk_sys(clk), .i_sys_rst(rst),
    .i_clk_en(en), .i_status(st), .i_logic_lines(ln), .i_cfg_a(ca), .i_cfg_b(cb),
    .o_ind_line(ind), .o_ind_line_used(used), .o_start_locked(locked),
    .o_dirty_window(dirty), .o_cfg_conflict(conf));
  isr_plc_model u_plc (.i_line_p(ind[0]), .i_line_n(ind[1]), .i_sso_on(st.sso_state),
    .o_pair_ok(pair_ok), .o_release(rel_ok));
  function automatic logic on(isr_chan_cfg_s c);
    return c.fn == ISR_FN_DIRECT_E || c.fn == ISR_FN_INVERT_E;
  endfunction : on
  function automatic logic src_val(logic [4:0] s);
    logic [31:0] v;
    v = {ln, st.magnet & st.opt_bridge, st.field_free, st.opt_bridge, st.magnet,
         st.sso_state, st.sso_fault, st.muting, st.led_yellow,
         st.weak_beam & ~st.weak_edge_only, run >= DC, st.error | st.fault,
         st.teach_ovr, st.teach_pc, e_lock & st.start_lock_en, 2'h1};
    return v[s];
  endfunction : src_val
  // Channel A is applied last so it wins a shared line
  function automatic void model();
    isr_chan_cfg_s c[2] = '{cb, ca};
    {e_ind, e_used} = '0;
    foreach (c[i]) begin
      if (on(c[i])) begin
        e_ind[c[i].line] = src_val(c[i].src) ^ (c[i].fn == ISR_FN_INVERT_E);
        e_used[c[i].line] = 1'b1;
      end
    end
    e_conf = on(ca) && on(cb) && ca.line == cb.line;
  endfunction : model
  task automatic check(logic [3:0] seen, logic [3:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic step();
    if (rst) begin
      {run, e_lock, e_ind, e_used, e_conf} = {32'h0, 1'b1, 9'h000};
    end else if (en) begin
      run = (st.weak_beam && !st.weak_edge_only) ? (run < DC ? run + 1 : DC) : 0;
      model();
      if (st.start_unlocked) e_lock = 1'b0;
    end
    @(negedge clk);
    check(ind, e_ind);
    check(used, e_used);
    check(conf, e_conf);
    check(locked, e_lock);
    check(dirty, run >= DC);
  endtask : step
  task automatic rnd_in();
    st = 15'($random(seed));
    ln = 16'($random(seed));
    ca = 9'($random(seed));
    cb = 9'($random(seed));
    en = ($random(seed) & 3) != 0;
    if (e_lock) st.start_unlocked = 1'b0;
  endtask : rnd_in
  task automatic final_report();
    $display("Checks %0d, errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report
  initial begin
    repeat (20) step();
    rst = 1'b0;
    step();
    // Every source code as an antivalent pair, both orientations
    for (int k = 0; k < 64; k++) begin
      rnd_in();
      en = 1'b1;
      ca = {k[5] ? ISR_FN_INVERT_E : ISR_FN_DIRECT_E, k[4:0], 2'h0};
      cb = {k[5] ? ISR_FN_DIRECT_E : ISR_FN_INVERT_E, k[4:0], 2'h1};
      step();
      check(pair_ok, 1'b1);
      check(rel_ok, e_ind[0] & st.sso_state);
    end
    repeat (400) begin
      rnd_in();
      step();
    end
    // Weak held past the dirty span, then dropped
    for (int k = 0; k < 26; k++) begin
      rnd_in();
      {en, st.weak_beam, st.weak_edge_only} = {1'b1, k < 25, 1'b0};
      ca = {ISR_FN_DIRECT_E, `ISR_SRC_DIRTY, 2'h2};
      step();
    end
    rnd_in();
    {en, st.start_unlocked, ca.fn, cb.fn} = {2'h3, ISR_FN_OFF_E, ISR_FN_OFF_E};
    step();
    repeat (100) begin
      rnd_in();
      step();
    end
    final_report();
  end
  initial begin
    #20000;
    err_total++;
    final_report();
  end
endmodule : testbench
`default_nettype wire
